// >>> core/eem_pkg.sv
// Package for the two-wire bus master that drives the serial memory
package eem_pkg;
  // System clock rate
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned CLK_NS        = 1000000000 / CLK_HZ;
  // Quarter period of the serial clock, at 100 kHz bus rate
  localparam int unsigned QUARTER_NS    = 2500;
  localparam int unsigned QUARTER_CYC   = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  // Fixed control code carried in the upper nibble of the first byte
  localparam logic [3:0]  CTRL_CODE     = 4'ha;
  localparam int unsigned CODE_POS      = 4;
  localparam int unsigned SEL_POS       = 1;
  localparam int unsigned DIR_POS       = 0;
  // Direction bit values
  localparam logic        DIR_READ      = 1'h1;
  localparam logic        DIR_WRITE     = 1'h0;
  // Longest internal write cycle of the memory
  localparam int unsigned WRITE_CYCLE_MS  = 5;
  localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_MS * (CLK_HZ / 1000);
  // Controller states
  typedef enum logic [7:0] {
    EEM_IDLE  = 8'h01,
    EEM_START = 8'h02,
    EEM_BIT   = 8'h04,
    EEM_ACK   = 8'h08,
    EEM_WAIT  = 8'h10,
    EEM_STOP  = 8'h20,
    EEM_DONE  = 8'h40,
    EEM_HOLD  = 8'h80
  } eem_state_t;
endpackage : eem_pkg

// >>> core/eem_master.sv
// Two-wire bus master that clocks bytes to and from the serial memory
// How it works
// - Start is SDA falling while SCL is high; this master makes it.
// - Stop is SDA rising while SCL is high; this master makes it.
// - A command opens with a Start condition when issued from idle or with cmd_start_i set.
// - An operation closes with a Stop after the acknowledge of a byte sent with cmd_stop_i set or refused.
// - SDA changes only while SCL is low, stable through the high phase.
// - One SCL pulse per bit; received bits are sampled mid high phase.
// - A transfer begins only when both lines are seen high.
// - Only this master drives SCL, Start, Stop, direction and byte count.
// - The master acknowledges every byte it receives except the last.
// - A ninth SCL pulse follows every byte for the acknowledge.
// - When acknowledging, SDA goes low before SCL rises, held through high.
// - The last read byte is left unacknowledged, SDA high.
// - Eight devices share a bus, each with a unique select combination.
// - Chip-select outputs hold valid levels before any bus operation.
// - First byte carries control code 1010 and three select bits.
// - Last bit of first byte: 1 is read, 0 is write.
`timescale 1ns/1ns
module eem_master #(
  parameter int unsigned WRITE_WAIT_CYC = eem_pkg::WRITE_CYCLE_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Byte command port
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_start_i,
  input  wire logic       cmd_stop_i,
  input  wire logic       cmd_read_i,
  input  wire logic       cmd_last_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  output logic            rsp_nack_o,
  // Chip-select and write-protect straps toward the memory
  input  wire logic [2:0] sel_cfg_i,
  input  wire logic       wp_cfg_i,
  output logic            chip_select_in_0_o,
  output logic            chip_select_in_1_o,
  output logic            chip_select_in_2_o,
  output logic            wp_o,
  // Open-drain bus lines
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       scl_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       sda_i
);
  import eem_pkg::*;

  localparam int unsigned QW = $clog2(QUARTER_CYC + 1);
  localparam int unsigned WW = $clog2(WRITE_WAIT_CYC + 1);

  eem_state_t      state_q, state_d;
  logic [QW-1:0]   qcnt_q, qcnt_d;
  logic [1:0]      phase_q, phase_d;
  logic [2:0]      bit_q, bit_d;
  logic [7:0]      sh_q, sh_d;
  logic            rd_q, rd_d, last_q, last_d, stop_q, stop_d;
  logic            scl_lo_q, scl_lo_d, sda_lo_q, sda_lo_d;
  logic            rv_q, rv_d, nack_q, nack_d;
  logic [7:0]      rdat_q, rdat_d;
  logic [WW-1:0]   wcnt_q, wcnt_d;
  logic [1:0]      scl_s_q, sda_s_q;
  logic [2:0]      cs_q;
  logic            wp_q;
  logic            tick;

  // Two-flop synchronisers for the bus lines
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_q <= 3'h0;
      wp_q <= 1'h0;
    end else begin
      cs_q <= sel_cfg_i;
      wp_q <= wp_cfg_i;
    end
  end
  assign chip_select_in_0_o = cs_q[0];
  assign chip_select_in_1_o = cs_q[1];
  assign chip_select_in_2_o = cs_q[2];
  assign wp_o               = wp_q;

  // Quarter-period enable
  assign tick = (qcnt_q == QW'(QUARTER_CYC - 1));

  // Only this master drives SCL; open-drain, low only
  assign scl_o       = 1'h0;
  assign sda_o       = 1'h0;
  assign scl_oe_o    = scl_lo_q;
  assign sda_oe_o    = sda_lo_q;
  assign cmd_ready_o = (state_q == EEM_IDLE) || (state_q == EEM_HOLD);
  assign rsp_valid_o = rv_q;
  assign rsp_data_o  = rdat_q;
  assign rsp_nack_o  = nack_q;

  // Next-state logic for the bit engine
  always_comb begin
    state_d  = state_q;
    qcnt_d   = tick ? '0 : qcnt_q + QW'(1);
    phase_d  = phase_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    rd_d     = rd_q;
    last_d   = last_q;
    stop_d   = stop_q;
    scl_lo_d = scl_lo_q;
    sda_lo_d = sda_lo_q;
    rv_d     = 1'h0;
    nack_d   = nack_q;
    rdat_d   = rdat_q;
    wcnt_d   = wcnt_q;
    case (state_q)
      EEM_IDLE, EEM_HOLD: begin
        qcnt_d = '0;
        if (cmd_valid_i && (state_q == EEM_HOLD || (scl_s_q[1] && sda_s_q[1]))) begin
          // Command byte shifted out MSB first
          sh_d    = cmd_data_i;
          rd_d    = cmd_read_i;
          last_d  = cmd_last_i;
          stop_d  = cmd_stop_i;
          bit_d   = 3'h7;
          phase_d = 2'h0;
          // Command opens with start; from idle always
          state_d = (cmd_start_i || state_q == EEM_IDLE) ? EEM_START : EEM_BIT;
          if (state_q == EEM_HOLD && cmd_start_i) begin
            sda_lo_d = 1'h0;
          end
        end
      end
      EEM_START: if (tick) begin
        phase_d = phase_q + 2'h1;
        case (phase_q)
          2'h0: scl_lo_d = 1'h0;
          2'h1: sda_lo_d = 1'h1;
          2'h2: scl_lo_d = 1'h1;
          default: begin
            state_d = EEM_BIT;
            phase_d = 2'h0;
          end
        endcase
      end
      EEM_BIT, EEM_ACK: if (tick) begin
        phase_d = phase_q + 2'h1;
        case (phase_q)
          2'h0: begin
            if (state_q == EEM_BIT) begin
              sda_lo_d = rd_q ? 1'h0 : !sh_q[7];
            end else begin
              sda_lo_d = rd_q && !last_q;
            end
          end
          2'h1: scl_lo_d = 1'h0;
          2'h2: begin
            if (state_q == EEM_BIT) begin
              sh_d = {sh_q[6:0], sda_s_q[1]};
            end else if (!rd_q) begin
              nack_d = sda_s_q[1];
            end
          end
          default: begin
            scl_lo_d = 1'h1;
            phase_d  = 2'h0;
            if (state_q == EEM_BIT) begin
              bit_d = bit_q - 3'h1;
              if (bit_q == 3'h0) begin
                state_d = EEM_ACK;
              end
            end else begin
              rv_d     = 1'h1;
              rdat_d   = sh_q;
              state_d  = (stop_q || nack_q) ? EEM_STOP : EEM_HOLD;
            end
          end
        endcase
        if (state_q == EEM_BIT && phase_q == 2'h0) begin
          nack_d = 1'h0;
        end
      end
      EEM_STOP: if (tick) begin
        phase_d = phase_q + 2'h1;
        case (phase_q)
          2'h0: sda_lo_d = 1'h1;
          2'h1: scl_lo_d = 1'h0;
          2'h2: sda_lo_d = 1'h0;
          default: begin
            phase_d = 2'h0;
            wcnt_d  = '0;
            // Allow a write cycle after a write unless write-protect is set
            state_d = (rd_q || wp_q) ? EEM_IDLE : EEM_WAIT;
          end
        endcase
      end
      EEM_WAIT: begin
        qcnt_d = '0;
        wcnt_d = wcnt_q + WW'(1);
        if (wcnt_q == WW'(WRITE_WAIT_CYC - 1)) begin
          state_d = EEM_IDLE;
        end
      end
      default: state_d = EEM_IDLE;
    endcase
  end

  // Register the bit engine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q  <= EEM_IDLE;
      qcnt_q   <= '0;
      phase_q  <= 2'h0;
      bit_q    <= 3'h7;
      sh_q     <= 8'h00;
      rd_q     <= 1'h0;
      last_q   <= 1'h0;
      stop_q   <= 1'h0;
      scl_lo_q <= 1'h0;
      sda_lo_q <= 1'h0;
      rv_q     <= 1'h0;
      nack_q   <= 1'h0;
      rdat_q   <= 8'h00;
      wcnt_q   <= '0;
    end else begin
      state_q  <= state_d;
      qcnt_q   <= qcnt_d;
      phase_q  <= phase_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      rd_q     <= rd_d;
      last_q   <= last_d;
      stop_q   <= stop_d;
      scl_lo_q <= scl_lo_d;
      sda_lo_q <= sda_lo_d;
      rv_q     <= rv_d;
      nack_q   <= nack_d;
      rdat_q   <= rdat_d;
      wcnt_q   <= wcnt_d;
    end
  end

  // Start: SDA falls only with SCL released
  a_start_shape: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == EEM_START && $rose(sda_lo_q)) |-> !scl_lo_q)
    else $error("start made with scl low");
  // Stop: SDA rises only with SCL released
  a_stop_shape: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == EEM_STOP && $fell(sda_lo_q)) |-> !scl_lo_q)
    else $error("stop made with scl low");
  // Data changes only while SCL is held low
  a_data_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    ((state_q == EEM_BIT || state_q == EEM_ACK) && $changed(sda_lo_q)) |-> scl_lo_q)
    else $error("sda moved while scl high");
  // Released SCL stays high at least three clocks
  a_bit_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(scl_lo_q) |=> !scl_lo_q [*2])
    else $error("scl high pulse too short");
  // Leaving idle needs an idle bus
  a_idle_bus: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == EEM_IDLE && state_d != EEM_IDLE) |-> (scl_s_q[1] && sda_s_q[1]))
    else $error("transfer began on busy bus");
  // Ack slot always follows the eighth bit
  a_ninth_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == EEM_BIT && tick && phase_q == 2'h3 && bit_q == 3'h0) |=> state_q == EEM_ACK)
    else $error("ack slot missing");
  // Ack of a read byte is low unless it is the last
  a_read_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == EEM_ACK && phase_q == 2'h2 && rd_q) |-> (sda_lo_q == !last_q))
    else $error("read ack level wrong");
  // Write cycle wait ends by the bound
  a_write_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == EEM_WAIT) |-> (wcnt_q < WW'(WRITE_WAIT_CYC)))
    else $error("write wait overran");
endmodule : eem_master

// >>> tb/eem_mem_model.sv
// Behavioural serial memory slave seen from the two-wire bus
`timescale 1ns/1ns
module eem_mem_model #(
  parameter int BUSY_NS = 150000,
  parameter int spike_filter_width = 50
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [2:0] cs_i,
  input  wire logic       wp_i,
  output logic            sda_oe_o
);
  logic [7:0] sh_q, mem_q;
  logic       act_q, rd_q, ctl_q, wr_q, busy_q;
  int         n_q;
  // Power-up state, bus released
  initial begin
    sda_oe_o = 0; act_q = 0; busy_q = 0; rd_q = 0; wr_q = 0; ctl_q = 0; n_q = 0;
    mem_q = 8'h3c;
  end
  // Start kept only if it outlasts a spike
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    #spike_filter_width;
    if (sda_i === 1'b0 && scl_i === 1'b1) begin
      act_q = 1; n_q = 0; ctl_q = 1; wr_q = 0; rd_q = 0;
    end
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    act_q = 0;
    if (wr_q && !wp_i) begin
      wr_q = 0; busy_q = 1; #BUSY_NS busy_q = 0;
    end
  end
  // sample high phase, master refusal ends read
  always @(posedge scl_i) if (act_q) begin
    if (n_q < 8) sh_q = {sh_q[6:0], sda_i};
    else if (rd_q && sda_i) act_q = 0;
    n_q++;
  end
  always @(negedge scl_i) begin
    #300;
    if (!act_q) sda_oe_o = 0;
    else if (n_q == 8 && ctl_q) begin
      ctl_q = 0;
      rd_q = sh_q[0];
      act_q = sh_q[7:4] == 4'ha && sh_q[3:1] == cs_i && !busy_q;
      sda_oe_o = act_q;
    end else if (n_q == 8) begin
      // ack written byte, store unless protected
      sda_oe_o = !rd_q;
      wr_q = !rd_q;
      if (!rd_q && !wp_i) mem_q = sh_q;
    end else begin
      if (n_q == 9) n_q = 0;
      sda_oe_o = rd_q && !mem_q[7 - n_q];
    end
  end
endmodule : eem_mem_model

// >>> tb/eem_master_test.sv
// Self-checking bench for the two-wire bus master against a memory model
`timescale 1ns/1ns
module eem_master_test;
  import eem_pkg::*;
  localparam logic [10:0] ACK_W = 11'h200;
  localparam logic [10:0] NAK_W = 11'h300;
  logic        clk_i, rst_i, cmd_valid_i, cmd_start_i, cmd_stop_i, cmd_read_i, cmd_last_i;
  logic [7:0]  cmd_data_i, rsp_data_o, dat;
  logic [2:0]  sel_cfg_i, sel;
  logic        wp_cfg_i, cmd_ready_o, rsp_valid_o, rsp_nack_o, cs0, cs1, cs2, wp;
  logic        scl_oe_o, sda_oe_o, mem_oe, scl, sda, scl_o, sda_o;
  logic [10:0] expq[$];
  logic [10:0] e;
  int          fail_count = 0;
  int          n_compared = 0;
  // Open-drain wires with pull-ups
  assign scl = scl_oe_o ? scl_o : 1'b1;
  assign sda = (sda_oe_o ? sda_o : 1'b1) && !mem_oe;
  eem_master #(.WRITE_WAIT_CYC(20)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_start_i(cmd_start_i), .cmd_stop_i(cmd_stop_i), .cmd_read_i(cmd_read_i),
    .cmd_last_i(cmd_last_i), .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_nack_o(rsp_nack_o), .sel_cfg_i(sel_cfg_i),
    .wp_cfg_i(wp_cfg_i), .chip_select_in_0_o(cs0), .chip_select_in_1_o(cs1),
    .chip_select_in_2_o(cs2), .wp_o(wp), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .scl_i(scl),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sda_i(sda));
  eem_mem_model u_mem (.scl_i(scl), .sda_i(sda), .cs_i({cs2, cs1, cs0}), .wp_i(wp),
    .sda_oe_o(mem_oe));
  // Clock
  initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  // Verdict and end of run
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Bounded wait for the ready level
  task automatic wait_ready(input logic lvl);
    int k;
    for (k = 0; k < 4000 && cmd_ready_o !== lvl; k++) begin
      @(posedge clk_i);
      #1;
    end
    if (k == 4000) begin
      fail_count++;
      $display("wrong value cmd_ready expected %b seen %b", lvl, cmd_ready_o);
      test_done();
    end
  endtask : wait_ready
  // One byte command; flags are start, stop, read, last
  task automatic cmd(input logic [3:0] f, input logic [7:0] d, input logic [10:0] ex);
    wait_ready(1'b1);
    expq.push_back(ex);
    @(posedge clk_i);
    {cmd_start_i, cmd_stop_i, cmd_read_i, cmd_last_i} <= f;
    cmd_data_i  <= d;
    cmd_valid_i <= 1'b1;
    wait_ready(1'b0);
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
  endtask : cmd
  // Oldest expectation against each finished byte
  always @(posedge clk_i) if (rsp_valid_o === 1'b1) begin
    e = (expq.size() > 0) ? expq.pop_front() : 11'h7ff;
    n_compared++;
    if (e[10] && rsp_data_o !== e[7:0]) begin
      $display("wrong value rsp_data expected %h seen %h", e[7:0], rsp_data_o);
      fail_count++;
    end
    if (e[9] && rsp_nack_o !== e[8]) begin
      $display("wrong value rsp_nack expected %b seen %b", e[8], rsp_nack_o);
      fail_count++;
    end
  end
  // Main sequence
  initial begin
    rst_i = 1; cmd_valid_i = 0; cmd_start_i = 0; cmd_stop_i = 0; cmd_read_i = 0;
    cmd_last_i = 0; cmd_data_i = 8'h00; wp_cfg_i = 0;
    void'($urandom(36));
    sel = 3'($urandom);
    dat = 8'($urandom);
    sel_cfg_i = sel;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    n_compared++;
    if ({cs2, cs1, cs0, wp, scl, sda} !== {sel, 3'b011}) begin
      $display("wrong value straps expected %b seen %b", {sel, 3'b011},
               {cs2, cs1, cs0, wp, scl, sda});
      fail_count++;
    end
    // Byte write, then a poll refused while the memory is busy
    cmd(4'b1000, {CTRL_CODE, sel, DIR_WRITE}, ACK_W);
    cmd(4'b0100, dat, ACK_W);
    cmd(4'b1100, {CTRL_CODE, sel, DIR_WRITE}, NAK_W);
    repeat (3000) @(posedge clk_i);
    // Two-byte read, the last one left unacknowledged
    cmd(4'b1000, {CTRL_CODE, sel, DIR_READ}, ACK_W);
    cmd(4'b0010, 8'h00, {3'b100, dat});
    cmd(4'b0111, 8'h00, {3'b100, dat});
    // Wrong select bits and wrong control code are refused
    for (int i = 0; i < 4; i++)
      cmd(4'b1100, i < 3 ? {CTRL_CODE, sel ^ (3'h1 << i), DIR_WRITE}
                         : {~CTRL_CODE, sel, DIR_WRITE}, NAK_W);
    // Protected write acked, repeated start reads old data at once
    wp_cfg_i <= 1'b1;
    cmd(4'b1000, {CTRL_CODE, sel, DIR_WRITE}, ACK_W);
    cmd(4'b0000, ~dat, ACK_W);
    cmd(4'b1000, {CTRL_CODE, sel, DIR_READ}, ACK_W);
    cmd(4'b0111, 8'h00, {3'b100, dat});
    // Protected write closed by a stop; the next command is acked at once
    cmd(4'b1000, {CTRL_CODE, sel, DIR_WRITE}, ACK_W);
    cmd(4'b0100, ~dat, ACK_W);
    cmd(4'b1100, {CTRL_CODE, sel, DIR_WRITE}, ACK_W);
    for (int k = 0; k < 4000 && expq.size() > 0; k++) @(posedge clk_i);
    if (expq.size() > 0) begin
      fail_count++;
      $display("wrong value pending responses expected 0 seen %0d", expq.size());
    end
    test_done();
  end
endmodule : eem_master_test
